// ==== cmpd_pkg.sv ====
// Operation
// - Enable pin high selects pin-controlled mode.
// - Enable floating, qualifier not low: range decides.
// - Serial mode: enable low, or enable floating, qualifier not low and range floating.
// - Range pin low reduces input full scale.
// - Swing pin low reduces output swing.
// - Edge pin picks positive or negative launch.
// - Edge pin floating selects double data rate.
// - Delay pin picks short or long calibration.
// - Delay pin floating: short delay, dual-edge sampling.
// - Serial mode: swing/edge/delay carry serial link.
package cmpd_pkg;

  // ==========================================================================
  // Tri-level strap encoding
  typedef enum logic [1:0] {
    CMPD_LOW = 2'h0,
    CMPD_HIGH = 2'h1,
    CMPD_FLOAT = 2'h3
  } cmpd_tri_t;

  localparam int STRAP_COUNT = 6;
  typedef cmpd_tri_t [STRAP_COUNT-1:0] cmpd_straps_t;

  // Strap positions in the resolved vector.
  localparam int IDX_ENABLE = 0;
  localparam int IDX_QUALIFIER = 1;
  localparam int IDX_RANGE = 2;
  localparam int IDX_SWING = 3;
  localparam int IDX_EDGE = 4;
  localparam int IDX_DELAY = 5;

  // Every strap floats until the first settled sample is applied.
  localparam cmpd_straps_t STRAPS_RESET = {STRAP_COUNT{CMPD_FLOAT}};

  // ==========================================================================
  // Settling filter
  typedef enum logic {
    CMPD_HOLD = 1'b0,
    CMPD_SETTLE = 1'b1
  } cmpd_state_t;

  localparam int CLK_PERIOD_PS = 25000;
  localparam int SETTLE_TIME_NS = 100;
  localparam int SETTLE_CYCLES = (SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETTLE_CNT_W = 3;
  localparam logic [SETTLE_CNT_W-1:0] SETTLE_LAST = SETTLE_CNT_W'(SETTLE_CYCLES - 1);

  // ==========================================================================
  // Serial link word
  localparam int WORD_BITS = 32;
  localparam int BIT_CNT_W = 5;
  localparam logic [BIT_CNT_W-1:0] BIT_LAST = 5'h1f;
  localparam int ADDR_LSB = 16;
  localparam int ADDR_W = 4;
  localparam int NUM_ADDR = 9;
  localparam logic [ADDR_W-1:0] ADDR_LIMIT = 4'h9;

endpackage

// ==== cmpd_link_if.sv ====
`timescale 1ns/1ps

// ============================================================================
// Word hand-off from the serial clock domain to the sample clock domain.
interface cmpd_link_if;
  logic [cmpd_pkg::WORD_BITS-1:0] word;
  logic word_tgl;

  modport shifter (
    output word,
    output word_tgl
  );

  modport core (
    input word,
    input word_tgl
  );
endinterface

// ==== cmpd_serial_shift.sv ====
`timescale 1ns/1ps

// ============================================================================
// Serial shifter on the link clock. A word is held stable for a whole
// following word time, which is what lets the core take it by toggle.
module cmpd_serial_shift (
  input wire logic serial_clock,
  input wire logic reset_n,
  input wire logic serial_data_in,
  input wire logic serial_chip_select,
  cmpd_link_if.shifter link
);

  logic frame_rst_n;
  logic [cmpd_pkg::WORD_BITS-2:0] shift_reg;
  logic [cmpd_pkg::WORD_BITS-2:0] shift_next;
  logic [cmpd_pkg::BIT_CNT_W-1:0] cnt_reg;
  logic [cmpd_pkg::BIT_CNT_W-1:0] cnt_next;
  logic [cmpd_pkg::WORD_BITS-1:0] word_reg;
  logic [cmpd_pkg::WORD_BITS-1:0] word_next;
  logic tgl_reg;
  logic tgl_next;

  // The clock stops between frames, so a dropped select clears the bit count at once.
  assign frame_rst_n = reset_n & serial_chip_select;

  // Shift MSB first; the last bit completes the word and flips the toggle.
  always_comb begin
    shift_next = {shift_reg[cmpd_pkg::WORD_BITS-3:0], serial_data_in};
    cnt_next = cnt_reg + 1'b1;
    word_next = word_reg;
    tgl_next = tgl_reg;
    if (cnt_reg == cmpd_pkg::BIT_LAST) begin
      word_next = {shift_reg, serial_data_in};
      tgl_next = ~tgl_reg;
    end
  end

  // Bit position and shift register, held clear outside a frame.
  always_ff @(posedge serial_clock or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      shift_reg <= '0;
      cnt_reg <= '0;
    end else begin
      shift_reg <= shift_next;
      cnt_reg <= cnt_next;
    end
  end

  // Completed word and its toggle survive the end of the frame.
  always_ff @(posedge serial_clock or negedge reset_n) begin
    if (!reset_n) begin
      word_reg <= '0;
      tgl_reg <= 1'b0;
    end else begin
      word_reg <= word_next;
      tgl_reg <= tgl_next;
    end
  end

  assign link.word = word_reg;
  assign link.word_tgl = tgl_reg;

  // ==========================================================================
  // Checks
  // The select drops between words, so only the global reset may cancel this check.
  a_word_complete: assert property (@(posedge serial_clock) disable iff (!reset_n)
    (cnt_reg == cmpd_pkg::BIT_LAST) |=> (tgl_reg != $past(tgl_reg)) &&
      (word_reg[0] == $past(serial_data_in)))
    else $error("Completed serial word did not flip the toggle.");

endmodule

// ==== cmpd_strap_decode.sv ====
`timescale 1ns/1ps

// ============================================================================
// Control-mode strap decode: pin-controlled settings or serial link.
module cmpd_strap_decode (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic serial_clock,
  input wire logic ext_ctrl_enable_hi,
  input wire logic ext_ctrl_enable_lo,
  input wire logic ext_ctrl_qualifier_hi,
  input wire logic ext_ctrl_qualifier_lo,
  input wire logic range_pin_hi,
  input wire logic range_pin_lo,
  input wire logic swing_pin_hi,
  input wire logic swing_pin_lo,
  input wire logic edge_pin_hi,
  input wire logic edge_pin_lo,
  input wire logic delay_pin_hi,
  input wire logic delay_pin_lo,
  output logic serial_mode,
  output logic full_scale_range_normal,
  output logic output_swing_level,
  output logic output_edge_select,
  output logic output_data_clock_ddr,
  output logic calibration_delay_select,
  output logic dual_edge_sampling,
  output logic [cmpd_pkg::WORD_BITS-1:0] serial_word,
  output logic serial_word_strobe,
  output logic serial_config_complete
);

  localparam int PAD_W = 2 * cmpd_pkg::STRAP_COUNT;

  // Resolve one strap from its two threshold comparators.
  function automatic cmpd_pkg::cmpd_tri_t resolve(input logic hi, input logic lo);
    if (hi && !lo) begin
      resolve = cmpd_pkg::CMPD_HIGH;
    end else if (lo && !hi) begin
      resolve = cmpd_pkg::CMPD_LOW;
    end else begin
      resolve = cmpd_pkg::CMPD_FLOAT;
    end
  endfunction

  // ==========================================================================
  // Pad synchronisers
  logic [PAD_W-1:0] pad_raw;
  logic [PAD_W-1:0] sync1_reg;
  logic [PAD_W-1:0] sync1_next;
  logic [PAD_W-1:0] sync2_reg;
  logic [PAD_W-1:0] sync2_next;
  cmpd_pkg::cmpd_straps_t seen;

  // Bit 2i+1 is the high comparator of strap i, bit 2i the low one.
  assign pad_raw = {delay_pin_hi, delay_pin_lo, edge_pin_hi, edge_pin_lo,
                    swing_pin_hi, swing_pin_lo, range_pin_hi, range_pin_lo,
                    ext_ctrl_qualifier_hi, ext_ctrl_qualifier_lo,
                    ext_ctrl_enable_hi, ext_ctrl_enable_lo};

  // Two stages; only the second stage is decoded.
  always_comb begin
    sync1_next = pad_raw;
    sync2_next = sync1_reg;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  // Tri-level resolution of every strap.
  always_comb begin
    for (int i = 0; i < cmpd_pkg::STRAP_COUNT; i++) begin
      seen[i] = resolve(sync2_reg[2*i+1], sync2_reg[2*i]);
    end
  end

  // ==========================================================================
  // Settling filter: a pin passing through mid-level while it slews must
  // not be taken as floating, so a new level is applied only once steady.
  cmpd_pkg::cmpd_state_t state_reg;
  cmpd_pkg::cmpd_state_t state_next;
  cmpd_pkg::cmpd_straps_t cand_reg;
  cmpd_pkg::cmpd_straps_t cand_next;
  cmpd_pkg::cmpd_straps_t applied_reg;
  cmpd_pkg::cmpd_straps_t applied_next;
  logic [cmpd_pkg::SETTLE_CNT_W-1:0] cnt_reg;
  logic [cmpd_pkg::SETTLE_CNT_W-1:0] cnt_next;

  always_comb begin
    state_next = state_reg;
    cand_next = cand_reg;
    cnt_next = cnt_reg;
    applied_next = applied_reg;
    case (state_reg)
      cmpd_pkg::CMPD_HOLD: begin
        if (seen != applied_reg) begin
          state_next = cmpd_pkg::CMPD_SETTLE;
          cand_next = seen;
          cnt_next = '0;
        end
      end
      cmpd_pkg::CMPD_SETTLE: begin
        if (seen != cand_reg) begin
          cand_next = seen;
          cnt_next = '0;
        end else if (cnt_reg == cmpd_pkg::SETTLE_LAST) begin
          applied_next = cand_reg;
          state_next = cmpd_pkg::CMPD_HOLD;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      default: begin
        state_next = cmpd_pkg::CMPD_HOLD;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= cmpd_pkg::CMPD_HOLD;
      cand_reg <= cmpd_pkg::STRAPS_RESET;
      applied_reg <= cmpd_pkg::STRAPS_RESET;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      cand_reg <= cand_next;
      applied_reg <= applied_next;
      cnt_reg <= cnt_next;
    end
  end

  // ==========================================================================
  // Mode and setting decode
  cmpd_pkg::cmpd_tri_t en_t;
  cmpd_pkg::cmpd_tri_t q_t;
  cmpd_pkg::cmpd_tri_t rng_t;
  cmpd_pkg::cmpd_tri_t sw_t;
  cmpd_pkg::cmpd_tri_t ed_t;
  cmpd_pkg::cmpd_tri_t dl_t;
  logic serial_calc;
  logic serial_mode_next;
  logic range_next;
  logic swing_next;
  logic edge_next;
  logic ddr_next;
  logic cal_next;
  logic des_next;

  assign en_t = applied_reg[cmpd_pkg::IDX_ENABLE];
  assign q_t = applied_reg[cmpd_pkg::IDX_QUALIFIER];
  assign rng_t = applied_reg[cmpd_pkg::IDX_RANGE];
  assign sw_t = applied_reg[cmpd_pkg::IDX_SWING];
  assign ed_t = applied_reg[cmpd_pkg::IDX_EDGE];
  assign dl_t = applied_reg[cmpd_pkg::IDX_DELAY];

  // In serial mode the pin settings hold their defaults, since those
  // pins then carry the link and their levels mean nothing.
  always_comb begin
    serial_calc = (en_t != cmpd_pkg::CMPD_HIGH) &&
      ((en_t == cmpd_pkg::CMPD_LOW) ||
       ((rng_t == cmpd_pkg::CMPD_FLOAT) && (q_t != cmpd_pkg::CMPD_LOW)));
    serial_mode_next = serial_calc;
    range_next = 1'b1;
    swing_next = 1'b1;
    edge_next = 1'b1;
    ddr_next = 1'b0;
    cal_next = 1'b0;
    des_next = 1'b0;
    if (!serial_calc) begin
      range_next = (rng_t != cmpd_pkg::CMPD_LOW);
      swing_next = (sw_t != cmpd_pkg::CMPD_LOW);
      edge_next = (ed_t != cmpd_pkg::CMPD_LOW);
      ddr_next = (ed_t == cmpd_pkg::CMPD_FLOAT);
      cal_next = (dl_t == cmpd_pkg::CMPD_HIGH);
      des_next = (dl_t == cmpd_pkg::CMPD_FLOAT);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_mode <= 1'b0;
      full_scale_range_normal <= 1'b1;
      output_swing_level <= 1'b1;
      output_edge_select <= 1'b1;
      output_data_clock_ddr <= 1'b0;
      calibration_delay_select <= 1'b0;
      dual_edge_sampling <= 1'b0;
    end else begin
      serial_mode <= serial_mode_next;
      full_scale_range_normal <= range_next;
      output_swing_level <= swing_next;
      output_edge_select <= edge_next;
      output_data_clock_ddr <= ddr_next;
      calibration_delay_select <= cal_next;
      dual_edge_sampling <= des_next;
    end
  end

  // ==========================================================================
  // Serial link: swing pin is the clock, edge pin data, delay pin select.
  cmpd_link_if link ();

  cmpd_serial_shift u_shift (
    .serial_clock(serial_clock),
    .reset_n(reset_n),
    .serial_data_in(edge_pin_hi),
    .serial_chip_select(delay_pin_lo),
    .link(link)
  );

  logic tgl_s1_reg;
  logic tgl_s2_reg;
  logic tgl_seen_reg;
  logic tgl_seen_next;
  logic [cmpd_pkg::WORD_BITS-1:0] word_next;
  logic strobe_next;
  logic [cmpd_pkg::NUM_ADDR-1:0] mask_reg;
  logic [cmpd_pkg::NUM_ADDR-1:0] mask_next;
  logic [cmpd_pkg::ADDR_W-1:0] word_addr;

  assign word_addr = link.word[cmpd_pkg::ADDR_LSB +: cmpd_pkg::ADDR_W];

  // Take a word on each toggle edge in serial mode; track which addresses were written.
  always_comb begin
    tgl_seen_next = tgl_s2_reg;
    word_next = serial_word;
    strobe_next = 1'b0;
    mask_next = serial_mode ? mask_reg : '0;
    if ((tgl_s2_reg != tgl_seen_reg) && serial_mode) begin
      word_next = link.word;
      strobe_next = 1'b1;
      if (word_addr < cmpd_pkg::ADDR_LIMIT) begin
        mask_next[word_addr] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tgl_s1_reg <= 1'b0;
      tgl_s2_reg <= 1'b0;
      tgl_seen_reg <= 1'b0;
      serial_word <= '0;
      serial_word_strobe <= 1'b0;
      mask_reg <= '0;
      serial_config_complete <= 1'b0;
    end else begin
      tgl_s1_reg <= link.word_tgl;
      tgl_s2_reg <= tgl_s1_reg;
      tgl_seen_reg <= tgl_seen_next;
      serial_word <= word_next;
      serial_word_strobe <= strobe_next;
      mask_reg <= mask_next;
      serial_config_complete <= &mask_next;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_enable_high_pins: assert property (en_t == cmpd_pkg::CMPD_HIGH |=> !serial_mode)
    else $error("Enable high did not give pin-controlled mode.");
  a_range_decides_mode: assert property (
    (en_t == cmpd_pkg::CMPD_FLOAT) && (q_t != cmpd_pkg::CMPD_LOW)
      |=> serial_mode == ($past(rng_t) == cmpd_pkg::CMPD_FLOAT))
    else $error("Range strap did not decide the mode.");
  a_enable_low_serial: assert property (en_t == cmpd_pkg::CMPD_LOW |=> serial_mode)
    else $error("Enable low did not give serial mode.");
  a_range_level: assert property (!serial_calc |=>
    full_scale_range_normal == ($past(rng_t) != cmpd_pkg::CMPD_LOW))
    else $error("Full-scale range does not follow its strap.");
  a_swing_level: assert property (!serial_calc && (sw_t == cmpd_pkg::CMPD_LOW)
    |=> !output_swing_level)
    else $error("Swing strap low did not reduce swing.");
  a_edge_polarity: assert property (!serial_calc && (ed_t != cmpd_pkg::CMPD_FLOAT)
    |=> !output_data_clock_ddr && (output_edge_select == ($past(ed_t) == cmpd_pkg::CMPD_HIGH)))
    else $error("Output edge does not follow its strap.");
  a_edge_float_ddr: assert property (!serial_calc && (ed_t == cmpd_pkg::CMPD_FLOAT)
    |=> output_data_clock_ddr)
    else $error("Floating edge strap did not select DDR.");
  a_cal_delay: assert property (!serial_calc && (dl_t == cmpd_pkg::CMPD_HIGH)
    |=> calibration_delay_select && !dual_edge_sampling)
    else $error("Delay strap high did not select long delay.");
  a_delay_float_des: assert property (!serial_calc && (dl_t == cmpd_pkg::CMPD_FLOAT)
    |=> dual_edge_sampling && !calibration_delay_select)
    else $error("Floating delay strap did not give DES with short delay.");
  a_settle_apply: assert property (
    (state_reg == cmpd_pkg::CMPD_HOLD) && (seen != applied_reg) ##1 (seen == cand_reg) [*4]
      |=> applied_reg == $past(cand_reg))
    else $error("Steady strap change was not applied after settling.");
  a_hold_static: assert property ($changed(applied_reg) |->
    $past(state_reg) == cmpd_pkg::CMPD_SETTLE)
    else $error("Applied straps changed without settling.");
  a_word_in_serial: assert property (serial_word_strobe |-> $past(serial_mode))
    else $error("Serial word taken outside serial mode.");

  c_serial_entered: cover property ($rose(serial_mode));
  c_ddr_selected: cover property ($rose(output_data_clock_ddr));
  c_des_selected: cover property ($rose(dual_edge_sampling));
  c_config_complete: cover property ($rose(serial_config_complete));

endmodule

// ==== cmpd_host_model.sv ====
`timescale 1ns/1ps

// ============================================================================
// Host model driving the tri-level straps and the serial link pins.
// The serial clock runs only inside a frame and stands low between frames.
// Pad order: enable, qualifier, range, swing, edge, delay.
module cmpd_host_model (
  output logic [5:0] strap_hi,
  output logic [5:0] strap_lo,
  output logic serial_clock
);
  cmpd_pkg::cmpd_tri_t pin_v [6];

  // A floating pad sits between the thresholds, so both comparators trip.
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      strap_hi[i] = (pin_v[i] != cmpd_pkg::CMPD_LOW);
      strap_lo[i] = (pin_v[i] != cmpd_pkg::CMPD_HIGH);
    end
  end

  // Every pad starts strapped high, which is pin-controlled mode.
  initial begin
    pin_v = '{default: cmpd_pkg::CMPD_HIGH};
    serial_clock = 1'b0;
  end

  function automatic cmpd_pkg::cmpd_tri_t lvl(input logic b);
    return b ? cmpd_pkg::CMPD_HIGH : cmpd_pkg::CMPD_LOW;
  endfunction

  // Sets all six pads at once, two bits per pad, enable in the low bits.
  task automatic set_all(input logic [11:0] p);
    for (int i = 0; i < 6; i++) begin
      pin_v[i] = cmpd_pkg::cmpd_tri_t'(p[2*i +: 2]);
    end
  endtask

  // Select low frames a word; data moves while the clock is low and is
  // taken on the rising edge, MSB first. Fewer than 32 bits aborts a frame.
  task automatic send_bits(input logic [31:0] word, input int nbits);
    pin_v[5] = cmpd_pkg::CMPD_LOW;
    for (int b = 31; b > 31 - nbits; b--) begin
      pin_v[4] = lvl(word[b]);
      #40;
      serial_clock = 1'b1;
      pin_v[3] = cmpd_pkg::CMPD_HIGH;
      #40;
      serial_clock = 1'b0;
      pin_v[3] = cmpd_pkg::CMPD_LOW;
    end
    // Released data shows the inverse of its last bit, never a held value.
    pin_v[4] = lvl(~word[32 - nbits]);
    pin_v[5] = cmpd_pkg::CMPD_HIGH;
  endtask
endmodule

// ==== cmpd_strap_decode_tb_top.sv ====
`timescale 1ns/1ps

// ============================================================================
// Self-checking bench for the control-mode strap decode.
module cmpd_strap_decode_tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [5:0] pad_hi;
  logic [5:0] pad_lo;
  logic serial_clock;
  logic serial_mode;
  logic range_normal;
  logic swing_normal;
  logic edge_pos;
  logic ddr;
  logic cal_long;
  logic des;
  logic [31:0] serial_word;
  logic serial_word_strobe;
  logic serial_config_complete;
  logic [31:0] word_v;
  logic [6:0] row;
  logic [1:0] v;
  int a;
  int miscompares = 0;
  int cmp_count = 0;

  // Mode rows: enable, qualifier, range codes, then the expected mode bit.
  logic [6:0] mode_rows [8] = '{7'h2e, 7'h0b, 7'h7f, 7'h68, 7'h6a, 7'h6f, 7'h66, 7'h01};

  always #12.5 clk = ~clk;

  cmpd_host_model cmpd_host_model_i (
    .strap_hi(pad_hi),
    .strap_lo(pad_lo),
    .serial_clock(serial_clock)
  );

  cmpd_strap_decode cmpd_strap_decode_i (
    .clk(clk),
    .reset_n(reset_n),
    .serial_clock(serial_clock),
    .ext_ctrl_enable_hi(pad_hi[0]),
    .ext_ctrl_enable_lo(pad_lo[0]),
    .ext_ctrl_qualifier_hi(pad_hi[1]),
    .ext_ctrl_qualifier_lo(pad_lo[1]),
    .range_pin_hi(pad_hi[2]),
    .range_pin_lo(pad_lo[2]),
    .swing_pin_hi(pad_hi[3]),
    .swing_pin_lo(pad_lo[3]),
    .edge_pin_hi(pad_hi[4]),
    .edge_pin_lo(pad_lo[4]),
    .delay_pin_hi(pad_hi[5]),
    .delay_pin_lo(pad_lo[5]),
    .serial_mode(serial_mode),
    .full_scale_range_normal(range_normal),
    .output_swing_level(swing_normal),
    .output_edge_select(edge_pos),
    .output_data_clock_ddr(ddr),
    .calibration_delay_select(cal_long),
    .dual_edge_sampling(des),
    .serial_word(serial_word),
    .serial_word_strobe(serial_word_strobe),
    .serial_config_complete(serial_config_complete)
  );

  wire [6:0] settings = {serial_mode, range_normal, swing_normal, edge_pos, ddr, cal_long, des};

  // Reset is held for three clock cycles.
  initial begin
    repeat (3) @(posedge clk);
    #2;
    reset_n = 1'b1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Inputs move a fixed 2 ns after the rising edge so samples are settled.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // Straps are static, so give the sync and settle filter time to apply.
  task automatic apply(input logic [11:0] p);
    cmpd_host_model_i.set_all(p);
    tick(14);
  endtask

  // Waits a bounded time for the word strobe; a missing one ends the run.
  task automatic watch_strobe(input logic want);
    int n;
    n = 0;
    while (serial_word_strobe !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    if (want && n == 40) begin
      miscompares++;
      $display("FAIL at %0t ns: no word strobe", $time);
      summarize();
    end else begin
      check(32'(serial_word_strobe), 32'(want), "word strobe");
      if (want) begin
        tick(1);
        check(32'(serial_word_strobe), 32'h0, "strobe width");
      end
    end
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    tick(1);
    check(32'(settings), 32'h38, "reset settings");
    check(serial_word, 32'h0, "reset word");
    check(32'({serial_word_strobe, serial_config_complete}), 32'h0, "reset flags");
    tick(4);
    // Pin mode with range, swing, edge and delay all low, then all high, then all floating except swing held high.
    for (int k = 0; k < 3; k++) begin
      v = (k == 2) ? 2'h3 : 2'(k);
      apply({v, v, (v == 2'h3) ? 2'h1 : v, v, 2'h1, 2'h1});
      check(32'(settings), 32'({1'b0, v != 2'h0, v != 2'h0, v != 2'h0, v == 2'h3,
        v == 2'h1, v == 2'h3}), "pin settings");
    end
    // A short range pulse must be filtered out.
    apply(12'h555);
    cmpd_host_model_i.set_all(12'h545);
    tick(2);
    cmpd_host_model_i.set_all(12'h555);
    // Look on every cycle: an unfiltered pulse would only show for a few cycles.
    for (int k = 0; k < 12; k++) begin
      tick(1);
      check(32'(range_normal), 32'h1, "range glitch");
    end
    // Mode decode; in serial mode the pin settings must read as defaults.
    for (int k = 0; k < 8; k++) begin
      row = mode_rows[k];
      apply({2'h1, 2'h0, 2'h0, row[2:1], row[4:3], row[6:5]});
      check(32'(settings), row[0] ? 32'h78 : 32'({1'b0, row[2:1] != 2'h0, 5'h02}),
        "mode");
    end
    // Serial mode: an aborted frame, an unmapped address, then all nine.
    apply(12'h404);
    check(32'(serial_mode), 32'h1, "serial mode");
    cmpd_host_model_i.send_bits(32'hffff_0000, 16);
    watch_strobe(1'b0);
    for (int k = 0; k < 10; k++) begin
      a = (k == 0) ? 10 : k - 1;
      word_v = {12'h3c5, 4'(a), 8'h00, 8'h5a ^ 8'(a)};
      cmpd_host_model_i.send_bits(word_v, 32);
      watch_strobe(1'b1);
      check(serial_word, word_v, "serial word");
      check(32'(serial_config_complete), 32'(a == 8), "config complete");
    end
    // Back to pin mode: completion clears and link words are dropped.
    apply(12'h555);
    check(32'({serial_mode, serial_config_complete}), 32'h0, "leave serial");
    cmpd_host_model_i.send_bits(32'h0123_4567, 32);
    watch_strobe(1'b0);
    check(serial_word, word_v, "held word");
    summarize();
  end
endmodule
